// ### bench/board_model.sv
// Purpose: board side of the sequencer, reset pin source, straps, phy reset line
// Assumes: the bench sets the straps before a load window opens
// Notes:   the phy reset line has no pull, so undriven it shows its last level inverted
module board_model
  import rst_seq_pkg::*;
(
  // clock
  input  wire logic      clk_in,
  // phy reset driver of the device
  input  wire logic      phy_reset_n_in,
  input  wire logic      phy_reset_oe_in,
  // board pins
  output logic           sys_reset_n_out,
  output strap_pins_type strap_pins_out,
  output logic           phy_pin_out
);
  timeunit 1ns;
  timeprecision 1ps;

  logic last_ff;

  // pin released and line level known at start
  initial begin
    sys_reset_n_out = 1'b1;
    last_ff = 1'b0;
  end

  // an undriven line must not look like a held value
  assign phy_pin_out = phy_reset_oe_in ? phy_reset_n_in : ~last_ff;
  always @(posedge clk_in) begin
    last_ff <= phy_pin_out;
  end

  // strap resistors, changed at once, with no wait for a clock edge
  task automatic set_straps(input strap_pins_type s);
    strap_pins_out = s;
  endtask

  // pin low ten cycles or more
  task automatic pulse_reset(input int unsigned cyc);
    @(posedge clk_in);
    #1;
    sys_reset_n_out = 1'b0;
    repeat ((cyc < RST_MIN_CYC) ? RST_MIN_CYC : cyc) @(posedge clk_in);
    #1;
    sys_reset_n_out = 1'b1;
  endtask
endmodule // board_model

// ### bench/reset_and_strap_config_sequencer_tb.sv
// Purpose: self-checking bench for the reset and strap sequencer
// Assumes: inputs change 1 ns after the rising edge
// Notes:   drivers queue expectations, the monitor compares as results appear
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin failures++; \
  $display("unexpected at %0t: %h want %h", $time, (a), (e)); end end
module reset_and_strap_config_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rst_seq_pkg::*;

  // ==========================================================================
  // signals
  logic           clk_in = 1'b0;
  logic           sys_rst_in = 1'b1;
  reg_req_type    reg_req = '0;
  logic           cmd_valid = 1'b0;
  logic [3:0]     cmd_type = 4'h0;
  logic           sys_reset_n, dev_rst, tri_st, phy_n, phy_oe, ovr, ee_req, phy_pin, rd_d;
  strap_pins_type straps, s0, s1, s2;
  strap_cfg_type  cfg;
  logic [7:0]     rd_data;
  logic [31:0]    rng = 32'h8654;
  int unsigned    failures, checked, ee_cnt, rst_c, tri_c, phy_c;
  logic [7:0]     q_rd[$];
  int unsigned    q_rst[$], q_tri[$], q_phy[$];

  always #5 clk_in = ~clk_in;

  reset_and_strap_config_sequencer dut (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .sys_reset_n_in(sys_reset_n),
    .strap_pins_in(straps), .reg_req_in(reg_req), .cmd_valid_in(cmd_valid),
    .cmd_type_in(cmd_type), .rd_data_out(rd_data), .device_reset_out(dev_rst),
    .outputs_tristate_out(tri_st), .phy_reset_n_out(phy_n), .phy_reset_oe_out(phy_oe),
    .cfg_out(cfg), .override_out(ovr), .eeprom_copy_req_out(ee_req));

  board_model board (
    .clk_in(clk_in), .phy_reset_n_in(phy_n), .phy_reset_oe_in(phy_oe),
    .sys_reset_n_out(sys_reset_n), .strap_pins_out(straps), .phy_pin_out(phy_pin));

  // ==========================================================================
  // helpers
  function logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  // tag sizes kept to 0..4 and subport byte to 0..3
  function automatic strap_pins_type mk_straps(input logic [31:0] r);
    strap_pins_type s;
    s = strap_pins_type'(r[17:0]);
    s.control_pins_a_strap_bus[2:0] = 3'(r[20:18] % 5);
    s.control_pins_a_strap_bus[7:5] = 3'(r[23:21] % 5);
    s.txaddr[2:0] = {1'b0, r[25:24]};
    return s;
  endfunction

  task automatic close_out();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_in);
    #1;
    reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_in);
    #1;
    reg_req.wr = 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    q_rd.push_back(e);
    @(posedge clk_in);
    #1;
    reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_in);
    #1;
    reg_req.rd = 1'b0;
  endtask

  task automatic cmd(input logic [3:0] t);
    @(posedge clk_in);
    #1;
    cmd_valid = 1'b1;
    cmd_type = t;
    @(posedge clk_in);
    #1;
    cmd_valid = 1'b0;
  endtask

  // bounded wait until the device runs with the phy released
  task automatic wait_run();
    int n;
    n = 0;
    while ((dev_rst !== 1'b0 || tri_st !== 1'b0 || phy_n !== 1'b1) && n < 2000) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    if (n >= 2000) begin
      failures++;
      close_out();
    end
    repeat (2) @(posedge clk_in);
  endtask

  task automatic check_cfg(input strap_pins_type s);
    logic [11:0]   m;
    logic [4:0]    md;
    strap_cfg_type ex;
    m = s.control_pins_a_strap_bus;
    // mode bits: eeprom init, pin 2, bus bit 11, pin 3, bus bit 10
    md = {s.txaddr[3], s.control_pins_a[0], m[11], s.control_pins_a[1], m[10]};
    ex = {md, m[3], m[4], m[2:0], m[8], m[9], m[7:5], s.txaddr[2:0], s.txaddr[2:0]};
    rd(MODE_SELECT_OFS, {3'h0, md});
    rd(MODE_SELECT_OFS, {3'h0, md});
    rd(TX_TAG_OFS, {3'h0, m[3], m[4], m[2:0]});
    rd(RX_TAG_OFS, {3'h0, m[8], m[9], m[7:5]});
    rd(TX_SUBPOS_OFS, {5'h0, s.txaddr[2:0]});
    rd(RX_SUBPOS_OFS, {5'h0, s.txaddr[2:0]});
    `CHK(cfg, ex)
  endtask

  // ==========================================================================
  // monitor: run lengths and read data against the oldest note
  always @(posedge clk_in) begin
    if (rd_d === 1'b1) `CHK(rd_data, q_rd.pop_front())
    rd_d <= reg_req.rd;
    `CHK(phy_oe, ~tri_st)
    if (ee_req === 1'b1) ee_cnt++;
    if (dev_rst === 1'b1) rst_c++;
    else begin
      if (rst_c > 0 && q_rst.size() > 0) `CHK(rst_c, q_rst.pop_front())
      rst_c = 0;
    end
    if (tri_st === 1'b1) tri_c++;
    else begin
      if (tri_c > 0 && q_tri.size() > 0) `CHK(tri_c, q_tri.pop_front())
      tri_c = 0;
    end
    if (phy_pin === 1'b0 && phy_oe === 1'b1) phy_c++;
    else begin
      if (phy_c > 0) `CHK(phy_c, q_phy.pop_front())
      phy_c = 0;
    end
  end

  // ==========================================================================
  // main sequence
  initial begin
    s0 = mk_straps(rnd());
    s0.txaddr[3] = 1'b1;
    board.set_straps(s0);
    q_phy.push_back(PHY_PULSE_CYC);
    repeat (16) @(posedge clk_in);
    #1;
    sys_rst_in = 1'b0;
    wait_run();
    check_cfg(s0);
    rd(PIN_CTRL_OFS, 8'h00);
    rd(16'h1234, 8'h00);
    $display("test power-on straps done");
    s1 = mk_straps(rnd());
    s1.txaddr[3] = 1'b0;
    board.set_straps(s1);
    repeat (8) @(posedge clk_in);
    check_cfg(s0);
    wr(MODE_SELECT_OFS, 8'hff);
    wr(RX_TAG_OFS, 8'hff);
    check_cfg(s0);
    wr(PIN_CTRL_OFS, 8'h01);
    `CHK(ovr, 1'b1)
    rd(PIN_CTRL_OFS, 8'h01);
    wr(TX_TAG_OFS, 8'h15);
    rd(TX_TAG_OFS, 8'h15);
    wr(MODE_SELECT_OFS, 8'hff);
    rd(MODE_SELECT_OFS, 8'h1f);
    wr(RX_SUBPOS_OFS, 8'h06);
    rd(RX_SUBPOS_OFS, 8'h06);
    $display("test override done");
    q_phy.push_back(SW_PHY_CYC);
    wr(PHY_RESET_OFS, 8'h01);
    rd(PHY_RESET_OFS, 8'h01);
    wait_run();
    rd(PHY_RESET_OFS, 8'h00);
    rd(PIN_CTRL_OFS, 8'h01);
    q_phy.push_back(SW_PHY_CYC + 5);
    wr(PHY_RESET_OFS, 8'h01);
    repeat (3) @(posedge clk_in);
    wr(PHY_RESET_OFS, 8'h01);
    wait_run();
    $display("test phy reset done");
    for (int i = 0; i < 8; i++) begin
      cmd_type = 4'(rnd());
      cmd((cmd_type == MSG_RESET) ? 4'h5 : cmd_type);
      repeat (3) @(posedge clk_in);
      `CHK(dev_rst, 1'b0)
    end
    q_rst.push_back(CMD_RESET_CYC + POST_RESET_CYC);
    q_tri.push_back(CMD_RESET_CYC + TRI_HOLD_CYC - TRI_DELAY_CYC);
    q_phy.push_back(PHY_PULSE_CYC);
    cmd(MSG_RESET);
    wait_run();
    check_cfg(s1);
    rd(PIN_CTRL_OFS, 8'h00);
    `CHK(ovr, 1'b0)
    $display("test command reset done");
    s2 = mk_straps(rnd());
    s2.txaddr[3] = 1'b1;
    board.set_straps(s2);
    q_phy.push_back(PHY_PULSE_CYC);
    board.pulse_reset(12);
    wait_run();
    check_cfg(s2);
    repeat (4) @(posedge clk_in);
    `CHK(ee_cnt, 2)
    `CHK(q_rst.size() + q_tri.size() + q_phy.size() + q_rd.size(), 0)
    $display("test pin reset done");
    close_out();
  end
endmodule // reset_and_strap_config_sequencer_tb

// ### logic/pin_sync.sv
// Purpose: three-stage synchroniser with agreement filter for board pins
// Assumes: inputs are asynchronous to clk_in
// Notes:   output moves only once stages two and three agree
module pin_sync import rst_seq_pkg::*; #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         clk_in,
  input  wire logic         sys_rst_in,
  // pins
  input  wire logic [W-1:0] pin_in,
  input  wire logic [W-1:0] rst_val_in,
  // filtered level
  output logic      [W-1:0] level_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] val;
  } sync_type;

  sync_type st_ff;
  sync_type nxt_st;

  // ==========================================================================
  // shift and filter; s1 feeds only s2 to keep metastability contained
  always_comb begin
    nxt_st     = st_ff;
    nxt_st.s1  = pin_in;
    nxt_st.s2  = st_ff.s1;
    nxt_st.s3  = st_ff.s2;
    for (int i = 0; i < W; i++) begin
      if (st_ff.s2[i] == st_ff.s3[i]) begin
        nxt_st.val[i] = st_ff.s3[i];
      end
    end
  end

  // reset value is a port level, so it is taken by the clocked path
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      st_ff <= {4{rst_val_in}};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign level_out = st_ff.val;

endmodule // pin_sync

// ### logic/pulse_timer.sv
// Purpose: retriggerable fixed-length pulse timer
// Assumes: load and clear are same-clock pulses
// Notes:   a load while busy restarts the full count
module pulse_timer import rst_seq_pkg::*; #(
  parameter int unsigned CNT_W = 5,
  parameter int unsigned LEN   = SW_PHY_CYC
) (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic sys_rst_in,
  // control
  input  wire logic load_in,
  input  wire logic clear_in,
  // status
  output logic      busy_out,
  output logic      done_out
);

  typedef struct packed {
    logic             busy;
    logic             done;
    logic [CNT_W-1:0] cnt;
  } timer_type;

  timer_type st_ff;
  timer_type nxt_st;

  // ==========================================================================
  // count down; clear beats load so a device reset kills the pulse
  always_comb begin
    nxt_st      = st_ff;
    nxt_st.done = 1'b0;
    if (clear_in) begin
      nxt_st.busy = 1'b0;
      nxt_st.cnt  = '0;
    end else if (load_in) begin
      nxt_st.busy = 1'b1;
      nxt_st.cnt  = CNT_W'(LEN - 1);
    end else if (st_ff.busy) begin
      if (st_ff.cnt == '0) begin
        nxt_st.busy = 1'b0;
        nxt_st.done = 1'b1;
      end else begin
        nxt_st.cnt = st_ff.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign busy_out = st_ff.busy;
  assign done_out = st_ff.done;

endmodule // pulse_timer

// ### logic/reset_and_strap_config_sequencer.sv
// Purpose: sequences device and phy resets and loads strap configuration
// Assumes: register accesses and reset commands come from the in-band cell decoder
// Notes:   outputs_tristate_out gates every output driver of the device
//
// Summary of operation
// - from reset pin rise, load straps for 16 cycles with outputs tri-stated
// - reset pin or in-band reset command resets device and phys
// - in-band reset command holds internal reset for 35 cycles
// - device stays in reset 16 cycles after either reset ends
// - tri-state two cycles after reset asserts, until 24 after it ends
// - after tri-state period, drive phy reset low eight cycles, then high
// - writing one to phy reset bit pulses phy reset low 16 cycles
// - phy reset bit clears itself when its pulse completes
// - override bit set makes pin-configured registers writable
// - cell-port width bit loads from strap bus bit 10
// - cell-port clock direction bit loads from control pin 3
// - utopia width bit loads from strap bus bit 11
// - management style bit loads from control pin 2
// - transmit tag register loads from strap bus bits 4 to 0
// - receive tag register loads from strap bus bits 9 to 5
// - transmit address straps 2 to 0 load both subport positions
// - transmit address strap 3 requests eeprom header copy at reset
// - while override bit is zero, pin-configured registers ignore writes
// - phy reset bit is bit zero of register 8007
module reset_and_strap_config_sequencer import rst_seq_pkg::*; (
  // clock and reset
  input  wire logic           clk_in,
  input  wire logic           sys_rst_in,
  // board pins
  input  wire logic           sys_reset_n_in,
  input  wire strap_pins_type strap_pins_in,
  // in-band register access and commands
  input  wire reg_req_type    reg_req_in,
  input  wire logic           cmd_valid_in,
  input  wire logic [3:0]     cmd_type_in,
  output logic [7:0]          rd_data_out,
  // reset outputs
  output logic                device_reset_out,
  output logic                outputs_tristate_out,
  output logic                phy_reset_n_out,
  output logic                phy_reset_oe_out,
  // configuration
  output strap_cfg_type       cfg_out,
  output logic                override_out,
  output logic                eeprom_copy_req_out
);

  typedef enum logic [2:0] {ST_RUN, ST_PIN, ST_CMD, ST_POST, ST_PHY} seq_state_type;

  typedef struct packed {
    seq_state_type state;
    logic [5:0]    cnt;
    logic [1:0]    asrt_cnt;
    strap_cfg_type cfg;
    logic          override;
    logic          phy_bit;
    logic          ee_req;
    logic [7:0]    rd_data;
  } seq_type;

  seq_type        st_ff;
  seq_type        nxt_st;
  logic           rst_pin_n;
  strap_pins_type straps;
  logic           dev_rst;
  logic           tri_on;
  logic           cmd_rst;
  logic           sw_start;
  logic           sw_busy;
  logic           sw_done;

  // write decode shared by all registers
  function automatic logic wr_hit(input reg_req_type r, input logic [15:0] ofs);
    return r.wr && (r.addr == ofs);
  endfunction

  // ==========================================================================
  // pin synchronisers
  // reset pin filtering
  pin_sync #(.W(1)) u_rst_sync (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .pin_in     (sys_reset_n_in),
    .rst_val_in (1'b1),
    .level_out  (rst_pin_n)
  );

  pin_sync #(.W($bits(strap_pins_type))) u_strap_sync (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .pin_in     (strap_pins_in),
    .rst_val_in ('0),
    .level_out  (straps)
  );

  // ==========================================================================
  // software phy reset pulse
  pulse_timer #(.CNT_W(5), .LEN(SW_PHY_CYC)) u_phy_timer (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .load_in    (sw_start),
    .clear_in   (dev_rst),
    .busy_out   (sw_busy),
    .done_out   (sw_done)
  );

  // ==========================================================================
  // decoded levels
  // in-band reset command
  assign cmd_rst = cmd_valid_in && (cmd_type_in == MSG_RESET);
  assign dev_rst = (st_ff.state == ST_PIN) || (st_ff.state == ST_CMD) ||
                   ((st_ff.state == ST_POST) && (st_ff.cnt < 6'(POST_RESET_CYC)));
  assign tri_on  = (((st_ff.state == ST_PIN) || (st_ff.state == ST_CMD)) &&
                    (st_ff.asrt_cnt >= 2'(TRI_DELAY_CYC))) || (st_ff.state == ST_POST);
  assign sw_start = !dev_rst && wr_hit(reg_req_in, PHY_RESET_OFS) && reg_req_in.wdata[0];

  // ==========================================================================
  // sequencer and register file
  always_comb begin
    nxt_st        = st_ff;
    nxt_st.ee_req = 1'b0;
    if (st_ff.asrt_cnt != 2'(TRI_DELAY_CYC)) begin
      nxt_st.asrt_cnt = st_ff.asrt_cnt + 1'b1;
    end
    unique case (st_ff.state)
      ST_RUN, ST_PHY: begin
        nxt_st.cnt = st_ff.cnt + 1'b1;
        if ((st_ff.state == ST_PHY) && (st_ff.cnt == 6'(PHY_PULSE_CYC - 1))) begin
          nxt_st.state = ST_RUN;
        end
      end
      ST_PIN: begin
        if (rst_pin_n) begin
          nxt_st.state = ST_POST;
          nxt_st.cnt   = '0;
        end
      end
      ST_CMD: begin
        nxt_st.cnt = st_ff.cnt + 1'b1;
        if (st_ff.cnt == 6'(CMD_RESET_CYC - 1)) begin
          nxt_st.state = ST_POST;
          nxt_st.cnt   = '0;
        end
      end
      ST_POST: begin
        nxt_st.cnt = st_ff.cnt + 1'b1;
        if (st_ff.cnt == 6'(TRI_HOLD_CYC - 1)) begin
          nxt_st.state = ST_PHY;
          nxt_st.cnt   = '0;
        end
      end
    endcase
    if (!rst_pin_n && (st_ff.state != ST_PIN)) begin
      nxt_st.state    = ST_PIN;
      nxt_st.asrt_cnt = tri_on ? st_ff.asrt_cnt : 2'd0; // floating outputs must stay floating
    end else if (cmd_rst && ((st_ff.state == ST_RUN) || (st_ff.state == ST_PHY))) begin
      nxt_st.state    = ST_CMD;
      nxt_st.cnt      = '0;
      nxt_st.asrt_cnt = '0;
    end

    if (dev_rst) begin
      nxt_st.override = 1'b0;
      nxt_st.phy_bit  = 1'b0;
      if ((st_ff.state == ST_POST) && (st_ff.cnt < 6'(STRAP_LOAD_CYC))) begin
        nxt_st.cfg.mode_select[MODE_CP_WIDTH]   = straps.control_pins_a_strap_bus[10];
        nxt_st.cfg.mode_select[MODE_CP_CLKDIR]  = straps.control_pins_a[1];
        nxt_st.cfg.mode_select[MODE_UT_WIDTH]   = straps.control_pins_a_strap_bus[11];
        nxt_st.cfg.mode_select[MODE_CONTROL_PINS_A_STYLE] = straps.control_pins_a[0];
        nxt_st.cfg.mode_select[MODE_EE_INIT]    = straps.txaddr[3];
        nxt_st.cfg.tx_tag_config = {straps.control_pins_a_strap_bus[3], straps.control_pins_a_strap_bus[4],
                                    straps.control_pins_a_strap_bus[2:0]};
        nxt_st.cfg.rx_tag_config = {straps.control_pins_a_strap_bus[8], straps.control_pins_a_strap_bus[9],
                                    straps.control_pins_a_strap_bus[7:5]};
        nxt_st.cfg.tx_subport_pos = straps.txaddr[2:0];
        nxt_st.cfg.rx_subport_pos = straps.txaddr[2:0];
        if (st_ff.cnt == 6'(STRAP_LOAD_CYC - 1)) begin
          nxt_st.ee_req = straps.txaddr[3];
        end
      end
    end else begin
      if (sw_start) begin
        nxt_st.phy_bit = 1'b1;
      end else if (sw_done) begin
        nxt_st.phy_bit = 1'b0;
      end
      if (wr_hit(reg_req_in, PIN_CTRL_OFS)) begin
        nxt_st.override = reg_req_in.wdata[0];
      end
      if (st_ff.override) begin
        if (wr_hit(reg_req_in, MODE_SELECT_OFS)) begin
          nxt_st.cfg.mode_select = reg_req_in.wdata[4:0];
        end
        if (wr_hit(reg_req_in, TX_TAG_OFS)) begin
          nxt_st.cfg.tx_tag_config = reg_req_in.wdata[4:0];
        end
        if (wr_hit(reg_req_in, RX_TAG_OFS)) begin
          nxt_st.cfg.rx_tag_config = reg_req_in.wdata[4:0];
        end
        if (wr_hit(reg_req_in, TX_SUBPOS_OFS)) begin
          nxt_st.cfg.tx_subport_pos = reg_req_in.wdata[2:0];
        end
        if (wr_hit(reg_req_in, RX_SUBPOS_OFS)) begin
          nxt_st.cfg.rx_subport_pos = reg_req_in.wdata[2:0];
        end
      end
    end

    // read mux; unmapped reads return zero
    if (reg_req_in.rd) begin
      unique case (reg_req_in.addr)
        MODE_SELECT_OFS: nxt_st.rd_data = {3'h0, st_ff.cfg.mode_select};
        PHY_RESET_OFS:   nxt_st.rd_data = {7'h00, st_ff.phy_bit};
        PIN_CTRL_OFS:    nxt_st.rd_data = {7'h00, st_ff.override};
        TX_TAG_OFS:      nxt_st.rd_data = {3'h0, st_ff.cfg.tx_tag_config};
        RX_TAG_OFS:      nxt_st.rd_data = {3'h0, st_ff.cfg.rx_tag_config};
        TX_SUBPOS_OFS:   nxt_st.rd_data = {5'h00, st_ff.cfg.tx_subport_pos};
        RX_SUBPOS_OFS:   nxt_st.rd_data = {5'h00, st_ff.cfg.rx_subport_pos};
        default:         nxt_st.rd_data = 8'h00;
      endcase
    end
  end

  // ==========================================================================
  // state register; power-on behaves like a pin reset
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      st_ff          <= '0;
      st_ff.state    <= ST_PIN;
      st_ff.asrt_cnt <= 2'(TRI_DELAY_CYC);
      st_ff.cfg      <= strap_cfg_type'(CFG_RST_VAL);
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================================
  // outputs
  assign device_reset_out     = dev_rst;
  assign outputs_tristate_out = tri_on;
  assign phy_reset_n_out      = !((st_ff.state == ST_PHY) || sw_busy);
  assign phy_reset_oe_out     = !tri_on;
  assign cfg_out              = st_ff.cfg;
  assign override_out         = st_ff.override;
  assign eeprom_copy_req_out  = st_ff.ee_req;
  assign rd_data_out          = st_ff.rd_data;

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  tri_delay_a: assert property (
    (cmd_rst && rst_pin_n && (st_ff.state == ST_RUN)) |=>
      (dev_rst && !tri_on) ##1 !tri_on ##1 tri_on)
    else $error("tri-state not two cycles after reset");

  cmd_len_a: assert property (
    ((st_ff.state == ST_CMD) && (st_ff.cnt == 6'd34) && rst_pin_n) |=>
      (st_ff.state == ST_POST) && (st_ff.cnt == 6'd0) && $past(st_ff.state == ST_CMD))
    else $error("command reset length wrong");

  post_len_a: assert property (
    $fell(dev_rst) |-> ($past(st_ff.state) == ST_POST) && ($past(st_ff.cnt) == 6'd15))
    else $error("reset released at wrong cycle");

  tri_hold_a: assert property (
    $fell(tri_on) |-> (st_ff.state == ST_PHY) && !phy_reset_n_out && ($past(st_ff.cnt) == 6'd23))
    else $error("tri-state hold wrong");

  phy_pulse_a: assert property (
    ($rose(st_ff.state == ST_PHY) && rst_pin_n) |-> (!phy_reset_n_out)[*8])
    else $error("phy reset pulse too short");

  sw_pulse_a: assert property (
    sw_start |=> (!phy_reset_n_out)[*8] ##8 !phy_reset_n_out)
    else $error("software phy pulse too short");

  self_clear_a: assert property (
    (st_ff.phy_bit && sw_done && !sw_start && !dev_rst) |=> !st_ff.phy_bit && phy_reset_n_out)
    else $error("phy reset bit did not clear");

  ro_guard_a: assert property (
    (!dev_rst && !st_ff.override && wr_hit(reg_req_in, MODE_SELECT_OFS)) |=>
      $stable(st_ff.cfg.mode_select))
    else $error("read-only register was written");

  override_wr_a: assert property (
    (!dev_rst && st_ff.override && wr_hit(reg_req_in, TX_TAG_OFS)) |=>
      (st_ff.cfg.tx_tag_config == $past(reg_req_in.wdata[4:0])))
    else $error("override write not taken");

  strap_hold_a: assert property (
    (!dev_rst && !reg_req_in.wr) |=> $stable(st_ff.cfg))
    else $error("configuration changed outside load window");

endmodule // reset_and_strap_config_sequencer

// ### pkg/rst_seq_pkg.sv
// Purpose: shared constants and carrier types for the reset and strap sequencer
// Assumes: one 100 MHz core clock; register access comes from the in-band cell decoder
// Notes:   register offsets are 16-bit in-band addresses
package rst_seq_pkg;

  // ==========================================================================
  // timing
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned RST_MIN_NS      = 100;
  // least time, rounded up to whole cycles
  localparam int unsigned RST_MIN_CYC     = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STRAP_LOAD_CYC  = 16;
  localparam int unsigned POST_RESET_CYC  = 16;
  localparam int unsigned CMD_RESET_CYC   = 35;
  localparam int unsigned TRI_DELAY_CYC   = 2;
  localparam int unsigned TRI_HOLD_CYC    = 24;
  localparam int unsigned PHY_PULSE_CYC   = 8;
  localparam int unsigned SW_PHY_CYC      = 16;

  // ==========================================================================
  // register offsets
  localparam logic [15:0] MODE_SELECT_OFS = 16'h8006;
  localparam logic [15:0] PHY_RESET_OFS   = 16'h8007;
  localparam logic [15:0] PIN_CTRL_OFS    = 16'h801a;
  localparam logic [15:0] TX_TAG_OFS      = 16'h8020;
  localparam logic [15:0] RX_TAG_OFS      = 16'h8021;
  localparam logic [15:0] TX_SUBPOS_OFS   = 16'h8022;
  localparam logic [15:0] RX_SUBPOS_OFS   = 16'h8023;

  // ==========================================================================
  // field positions and codes
  localparam int unsigned MODE_CP_WIDTH   = 0;
  localparam int unsigned MODE_CP_CLKDIR  = 1;
  localparam int unsigned MODE_UT_WIDTH   = 2;
  localparam int unsigned MODE_CONTROL_PINS_A_STYLE = 3;
  localparam int unsigned MODE_EE_INIT    = 4;
  localparam int unsigned TAG_HEC         = 3;
  localparam int unsigned TAG_LOC         = 4;
  localparam logic [3:0]  MSG_RESET       = 4'h3;
  localparam logic [7:0]  CFG_RST_VAL     = 8'h00;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic [11:0] control_pins_a_strap_bus;
    logic [1:0]  control_pins_a;   // pins 3 and 2
    logic [3:0]  txaddr;
  } strap_pins_type;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } reg_req_type;

  typedef struct packed {
    logic [4:0] mode_select;
    logic [4:0] tx_tag_config;
    logic [4:0] rx_tag_config;
    logic [2:0] tx_subport_pos;
    logic [2:0] rx_subport_pos;
  } strap_cfg_type;

endpackage
